// *** comparator_input_select_map.vh ***
// Register offsets, field layout and select codes for the comparator input select block
`ifndef COMPARATOR_INPUT_SELECT_MAP_VH
`define COMPARATOR_INPUT_SELECT_MAP_VH
`define CIS_ADDR_W          4
`define CIS_OFF_P0_A_CFG    4'h0
`define CIS_OFF_P0_B_CFG    4'h1
`define CIS_OFF_P0_WIN_CFG  4'h2
`define CIS_OFF_P0_STATUS   4'h3
`define CIS_OFF_P1_A_CFG    4'h4
`define CIS_OFF_P1_B_CFG    4'h5
`define CIS_OFF_P1_WIN_CFG  4'h6
`define CIS_OFF_P1_STATUS   4'h7
`define CIS_OFF_VERSION     4'h8
`define CIS_POS_LSB         0
`define CIS_NEG_LSB         4
`define CIS_SEL_W           3
`define CIS_WIN_W           2
`define CIS_CFG_RESET       8'h00
`define CIS_WIN_RESET       2'h0
`define CIS_VERSION_VALUE   32'h0000ABCD
`define SEL_PIN0            3'h0
`define SEL_PIN1            3'h1
`define SEL_CODE2           3'h2
`define SEL_CODE3           3'h3
`define SEL_CODE4           3'h4
`define SEL_CODE5           3'h5
`define SRC_NONE            4'h0
`define SRC_A_POS0          4'h1
`define SRC_A_POS1          4'h2
`define SRC_A_NEG0          4'h3
`define SRC_A_NEG1          4'h4
`define SRC_B_POS0          4'h5
`define SRC_B_POS1          4'h6
`define SRC_B_NEG0          4'h7
`define SRC_B_NEG1          4'h8
`define SRC_DAC0            4'h9
`define SRC_DAC1            4'hA
`define SRC_SUPPLY          4'hB
`endif

// *** comparator_input_select.v ***
// Input select decode for two comparator interface instances
//
// Operation
// - Two instances, both clocked by clk_in; the bus clock inputs are unused
// - Instance 0 pair 0, instance 1 pair 1
// - Config fields choose positive and negative inputs
// - A positive: pin0, pin1, first DAC
// - A negative: pins, B pins, supply, DAC
// - B positive: A negs, B pins, DAC, supply
// - B negative: pin0, pin1, second DAC
// - Window select picks common input pin
// - Instance 1 uses same encodings
// - Window ready needs both comparators ready
`timescale 1ns/1ps
`include "comparator_input_select_map.vh"
module comparator_input_select #(
  parameter [31:0] VERSION_ID = `CIS_VERSION_VALUE // Arbitrary value
) (
  input  wire                     clk_in,
  input  wire                     instance0_bus_clock_in,
  input  wire                     instance1_bus_clock_in,
  input  wire                     resetn_in,
  input  wire [`CIS_ADDR_W-1:0]   addr_in,
  input  wire [31:0]              wdata_in,
  input  wire                     wr_in,
  input  wire                     rd_in,
  output reg  [31:0]              rdata_out,
  input  wire [3:0]               comparator_ready_in,
  input  wire [1:0]               window_mode_in,
  output reg  [3:0]               pair0_comparator_a_pos_out,
  output reg  [3:0]               pair0_comparator_a_neg_out,
  output reg  [3:0]               pair0_comparator_b_pos_out,
  output reg  [3:0]               pair0_comparator_b_neg_out,
  output reg  [3:0]               pair1_comparator_a_pos_out,
  output reg  [3:0]               pair1_comparator_a_neg_out,
  output reg  [3:0]               pair1_comparator_b_pos_out,
  output reg  [3:0]               pair1_comparator_b_neg_out,
  output reg  [3:0]               pair0_window_common_out,
  output reg  [3:0]               pair1_window_common_out,
  output reg  [1:0]               window_ready_flag_out
);

  // Decoders shared by both instances
  function [3:0] a_pos_src;
    input [2:0] code;
    case (code)
      `SEL_PIN0:  a_pos_src = `SRC_A_POS0;
      `SEL_PIN1:  a_pos_src = `SRC_A_POS1;
      `SEL_CODE2: a_pos_src = `SRC_DAC0;
      default:    a_pos_src = `SRC_NONE;
    endcase
  endfunction

  function [3:0] a_neg_src;
    input [2:0] code;
    case (code)
      `SEL_PIN0:  a_neg_src = `SRC_A_NEG0;
      `SEL_PIN1:  a_neg_src = `SRC_A_NEG1;
      `SEL_CODE2: a_neg_src = `SRC_B_POS0;
      `SEL_CODE3: a_neg_src = `SRC_B_POS1;
      `SEL_CODE4: a_neg_src = `SRC_SUPPLY;
      `SEL_CODE5: a_neg_src = `SRC_DAC1;
      default:    a_neg_src = `SRC_NONE;
    endcase
  endfunction

  function [3:0] b_pos_src;
    input [2:0] code;
    case (code)
      `SEL_PIN0:  b_pos_src = `SRC_A_NEG0;
      `SEL_PIN1:  b_pos_src = `SRC_A_NEG1;
      `SEL_CODE2: b_pos_src = `SRC_B_POS0;
      `SEL_CODE3: b_pos_src = `SRC_B_POS1;
      `SEL_CODE4: b_pos_src = `SRC_DAC0;
      `SEL_CODE5: b_pos_src = `SRC_SUPPLY;
      default:    b_pos_src = `SRC_NONE;
    endcase
  endfunction

  function [3:0] b_neg_src;
    input [2:0] code;
    case (code)
      `SEL_PIN0:  b_neg_src = `SRC_B_NEG0;
      `SEL_PIN1:  b_neg_src = `SRC_B_NEG1;
      `SEL_CODE2: b_neg_src = `SRC_DAC1;
      default:    b_neg_src = `SRC_NONE;
    endcase
  endfunction

  function [3:0] win_src;
    input [1:0] code;
    case (code)
      2'h0:    win_src = `SRC_A_NEG0;
      2'h1:    win_src = `SRC_A_NEG1;
      2'h2:    win_src = `SRC_B_POS0;
      default: win_src = `SRC_B_POS1;
    endcase
  endfunction

  reg  [3:0]  rdy_meta_q;
  reg  [3:0]  rdy_q;
  reg  [1:0]  wmode_meta_q;
  reg  [1:0]  wmode_q;
  reg  [31:0] rdata_d;
  reg  [3:0]  p0_a_pos_d;
  reg  [3:0]  p0_a_neg_d;
  reg  [3:0]  p0_b_pos_d;
  reg  [3:0]  p0_b_neg_d;
  reg  [3:0]  p1_a_pos_d;
  reg  [3:0]  p1_a_neg_d;
  reg  [3:0]  p1_b_pos_d;
  reg  [3:0]  p1_b_neg_d;
  reg  [3:0]  p0_win_d;
  reg  [3:0]  p1_win_d;
  wire [1:0]  win_rdy;

  // One AND per pair feeds both the status read and the flag
  assign win_rdy = {rdy_q[2] & rdy_q[3], rdy_q[0] & rdy_q[1]};

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      rdy_meta_q   <= 4'h0;
      rdy_q        <= 4'h0;
      wmode_meta_q <= 2'h0;
      wmode_q      <= 2'h0;
    end else begin
      rdy_meta_q   <= comparator_ready_in;
      rdy_q        <= rdy_meta_q;
      wmode_meta_q <= window_mode_in;
      wmode_q      <= wmode_meta_q;
    end
  end

  // One copy per interface instance; all state runs on clk_in so no word crosses domains
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_pair
      wire [`CIS_ADDR_W-1:0] a_off;
      wire [`CIS_ADDR_W-1:0] b_off;
      wire [`CIS_ADDR_W-1:0] w_off;
      reg  [7:0]             a_cfg_d;
      reg  [7:0]             b_cfg_d;
      reg  [`CIS_WIN_W-1:0]  win_cfg_d;
      reg  [7:0]             a_cfg_q;
      reg  [7:0]             b_cfg_q;
      reg  [`CIS_WIN_W-1:0]  win_cfg_q;
      assign a_off = (p == 1) ? `CIS_OFF_P1_A_CFG : `CIS_OFF_P0_A_CFG;
      assign b_off = (p == 1) ? `CIS_OFF_P1_B_CFG : `CIS_OFF_P0_B_CFG;
      assign w_off = (p == 1) ? `CIS_OFF_P1_WIN_CFG : `CIS_OFF_P0_WIN_CFG;
      // Upper write data bits are dropped; an unmapped offset changes nothing
      always @* begin
        a_cfg_d   = a_cfg_q;
        b_cfg_d   = b_cfg_q;
        win_cfg_d = win_cfg_q;
        if (wr_in && addr_in == a_off)
          a_cfg_d = wdata_in[7:0];
        if (wr_in && addr_in == b_off)
          b_cfg_d = wdata_in[7:0];
        if (wr_in && addr_in == w_off)
          win_cfg_d = wdata_in[`CIS_WIN_W-1:0];
      end
      always @(posedge clk_in) begin
        if (!resetn_in) begin
          a_cfg_q   <= `CIS_CFG_RESET;
          b_cfg_q   <= `CIS_CFG_RESET;
          win_cfg_q <= `CIS_WIN_RESET;
        end else begin
          a_cfg_q   <= a_cfg_d;
          b_cfg_q   <= b_cfg_d;
          win_cfg_q <= win_cfg_d;
        end
      end
    end
  endgenerate

  always @* begin
    rdata_d = 32'h0000_0000;
    case (addr_in)
      `CIS_OFF_P0_A_CFG:   rdata_d = {24'h0, g_pair[0].a_cfg_q};
      `CIS_OFF_P0_B_CFG:   rdata_d = {24'h0, g_pair[0].b_cfg_q};
      `CIS_OFF_P0_WIN_CFG: rdata_d = {30'h0, g_pair[0].win_cfg_q};
      `CIS_OFF_P0_STATUS:  rdata_d = {29'h0, win_rdy[0], rdy_q[1:0]};
      `CIS_OFF_P1_A_CFG:   rdata_d = {24'h0, g_pair[1].a_cfg_q};
      `CIS_OFF_P1_B_CFG:   rdata_d = {24'h0, g_pair[1].b_cfg_q};
      `CIS_OFF_P1_WIN_CFG: rdata_d = {30'h0, g_pair[1].win_cfg_q};
      `CIS_OFF_P1_STATUS:  rdata_d = {29'h0, win_rdy[1], rdy_q[3:2]};
      `CIS_OFF_VERSION:    rdata_d = VERSION_ID;
      default:             rdata_d = 32'h0000_0000;
    endcase
  end

  // Route decode per pair; instance 1 reuses the instance 0 encodings
  always @* begin
    p0_a_pos_d = a_pos_src(g_pair[0].a_cfg_q[2:0]);
    p0_a_neg_d = a_neg_src(g_pair[0].a_cfg_q[6:4]);
    p0_b_pos_d = b_pos_src(g_pair[0].b_cfg_q[2:0]);
    p0_b_neg_d = b_neg_src(g_pair[0].b_cfg_q[6:4]);
    p1_a_pos_d = a_pos_src(g_pair[1].a_cfg_q[2:0]);
    p1_a_neg_d = a_neg_src(g_pair[1].a_cfg_q[6:4]);
    p1_b_pos_d = b_pos_src(g_pair[1].b_cfg_q[2:0]);
    p1_b_neg_d = b_neg_src(g_pair[1].b_cfg_q[6:4]);
    p0_win_d   = wmode_q[0] ? win_src(g_pair[0].win_cfg_q) : `SRC_NONE;
    p1_win_d   = wmode_q[1] ? win_src(g_pair[1].win_cfg_q) : `SRC_NONE;
  end

  // Routes are registered so pin changes never glitch the analog muxes
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_out                  <= 32'h0000_0000;
      pair0_comparator_a_pos_out <= `SRC_NONE;
      pair0_comparator_a_neg_out <= `SRC_NONE;
      pair0_comparator_b_pos_out <= `SRC_NONE;
      pair0_comparator_b_neg_out <= `SRC_NONE;
      pair1_comparator_a_pos_out <= `SRC_NONE;
      pair1_comparator_a_neg_out <= `SRC_NONE;
      pair1_comparator_b_pos_out <= `SRC_NONE;
      pair1_comparator_b_neg_out <= `SRC_NONE;
      pair0_window_common_out    <= `SRC_NONE;
      pair1_window_common_out    <= `SRC_NONE;
      window_ready_flag_out      <= 2'h0;
    end else begin
      rdata_out                  <= rd_in ? rdata_d : 32'h0000_0000;
      pair0_comparator_a_pos_out <= p0_a_pos_d;
      pair0_comparator_a_neg_out <= p0_a_neg_d;
      pair0_comparator_b_pos_out <= p0_b_pos_d;
      pair0_comparator_b_neg_out <= p0_b_neg_d;
      pair1_comparator_a_pos_out <= p1_a_pos_d;
      pair1_comparator_a_neg_out <= p1_a_neg_d;
      pair1_comparator_b_pos_out <= p1_b_pos_d;
      pair1_comparator_b_neg_out <= p1_b_neg_d;
      pair0_window_common_out    <= p0_win_d;
      pair1_window_common_out    <= p1_win_d;
      window_ready_flag_out      <= win_rdy;
    end
  end

endmodule // comparator_input_select

// *** comparator_pair_model.sv ***
// Comparator pair model: outputs become ready a startup delay after enable
`timescale 1ns/1ps
module comparator_pair_model #(
  parameter int STARTUP = 5
) (
  input  wire logic       clk_in,
  input  wire logic [3:0] enable_in,
  output logic      [3:0] ready_out = 4'h0
);
  int cnt [4] = '{default: 0};
  always @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= enable_in[i] ? (cnt[i] < STARTUP ? cnt[i] + 1 : cnt[i]) : 0;
      // Ready drops at once on disable, so the window flag sees a real loss
      ready_out[i] <= enable_in[i] && cnt[i] == STARTUP;
    end
  end
endmodule // comparator_pair_model

// *** comparator_input_select_checker.sv ***
// Assertion checker for the comparator input select block
`timescale 1ns/1ps
module comparator_input_select_checker (
  input wire        clk_in, resetn_in, wr_in,
  input wire [3:0]  addr_in, comparator_ready_in,
  input wire [31:0] wdata_in,
  input wire [1:0]  window_ready_flag_out,
  input wire [3:0]  pair0_comparator_a_pos_out, pair0_comparator_a_neg_out,
  input wire [3:0]  pair0_comparator_b_pos_out, pair0_comparator_b_neg_out,
  input wire [3:0]  pair1_comparator_a_neg_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire w0 = wr_in && addr_in == 4'h0;
  wire w1 = wr_in && addr_in == 4'h1;
  wire w4 = wr_in && addr_in == 4'h4;
  chk_a_pos_dac: assert property (w0 && wdata_in[2:0] == 3'h2 |-> ##2 pair0_comparator_a_pos_out == 4'h9)
    else $error("a positive route wrong");
  chk_a_neg_supply: assert property (w0 && wdata_in[6:4] == 3'h4 |-> ##2 pair0_comparator_a_neg_out == 4'hB)
    else $error("a negative route wrong");
  chk_b_pos_pin: assert property (w1 && wdata_in[2:0] == 3'h3 |-> ##2 pair0_comparator_b_pos_out == 4'h6)
    else $error("b positive route wrong");
  chk_b_neg_dac: assert property (w1 && wdata_in[6:4] == 3'h2 |-> ##2 pair0_comparator_b_neg_out == 4'hA)
    else $error("b negative route wrong");
  chk_bad_code: assert property (w0 && wdata_in[2:0] > 3'h2 |-> ##2 pair0_comparator_a_pos_out == 4'h0)
    else $error("invalid code not unconnected");
  chk_pair1_neg: assert property (w4 && wdata_in[6:4] == 3'h5 |-> ##2 pair1_comparator_a_neg_out == 4'hA)
    else $error("pair one route wrong");
  chk_win_ready: assert property (window_ready_flag_out[0] |-> $past(&comparator_ready_in[1:0], 3))
    else $error("window ready without both");
  chk_win_drop: assert property (!comparator_ready_in[1] |-> ##3 !window_ready_flag_out[0])
    else $error("window ready not cleared");
endmodule // comparator_input_select_checker

// *** comparator_input_select_test.sv ***
// Self-checking bench for the comparator input select block
`timescale 1ns/1ps
`include "comparator_input_select_map.vh"
module comparator_input_select_test;
  localparam [31:0] APOS = 32'h0000_0921, ANEG = 32'h00AB_6543;
  localparam [31:0] BPOS = 32'h00B9_6543, BNEG = 32'h0000_0A87;
  logic        clk_in = 1'b0, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [3:0]  addr_in = 4'h0, enable = 4'h0;
  logic [31:0] wdata_in = 32'h0;
  logic [1:0]  window_mode_in = 2'h0;
  wire  [3:0]  ready, r [0:9];
  wire  [31:0] rdata_out;
  wire  [1:0]  window_ready_flag_out;
  int          fails = 0, checked = 0, cycles = 0;
  comparator_pair_model #(.STARTUP(5)) u_comparator_pair_model (
    .clk_in(clk_in), .enable_in(enable), .ready_out(ready));
  comparator_input_select u_comparator_input_select (
    .clk_in(clk_in), .instance0_bus_clock_in(clk_in), .instance1_bus_clock_in(clk_in),
    .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .comparator_ready_in(ready), .window_mode_in(window_mode_in),
    .pair0_comparator_a_pos_out(r[0]), .pair0_comparator_a_neg_out(r[1]),
    .pair0_comparator_b_pos_out(r[2]), .pair0_comparator_b_neg_out(r[3]),
    .pair1_comparator_a_pos_out(r[4]), .pair1_comparator_a_neg_out(r[5]),
    .pair1_comparator_b_pos_out(r[6]), .pair1_comparator_b_neg_out(r[7]),
    .pair0_window_common_out(r[8]), .pair1_window_common_out(r[9]),
    .window_ready_flag_out(window_ready_flag_out));
  always #10 clk_in = ~clk_in;
  // Whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    if (++cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 check(rdata_out, exp);
  endtask
  task automatic t_inputs(input logic [3:0] a, input logic [31:0] pt, input logic [31:0] nt);
    for (int c = 0; c < 8; c++) begin
      wr(a, {25'h0, c[2:0], 1'b0, c[2:0]});
      @(posedge clk_in);
      #1 check({r[{a[2], a[0], 1'b1}], r[{a[2], a[0], 1'b0}]}, {nt[c*4+:4], pt[c*4+:4]});
      rd(a, {25'h0, c[2:0], 1'b0, c[2:0]});
    end
  endtask
  task automatic t_window();
    @(posedge clk_in);
    window_mode_in <= 2'h3;
    for (int c = 0; c < 4; c++) begin
      wr(`CIS_OFF_P0_WIN_CFG, c);
      wr(`CIS_OFF_P1_WIN_CFG, c);
      repeat (3) @(posedge clk_in);
      #1 check({r[9], r[8]}, {2{4'h3 + c[3:0]}});
    end
    @(posedge clk_in);
    window_mode_in <= 2'h0;
    repeat (5) @(posedge clk_in);
    #1 check({r[9], r[8]}, 8'h00);
  endtask
  task automatic t_ready();
    @(posedge clk_in);
    enable <= 4'h5;
    repeat (12) @(posedge clk_in);
    #1 check(window_ready_flag_out, 2'h0);
    @(posedge clk_in);
    enable <= 4'hF;
    repeat (12) @(posedge clk_in);
    #1 check(window_ready_flag_out, 2'h3);
    rd(`CIS_OFF_P0_STATUS, 32'h7);
    @(posedge clk_in);
    enable <= 4'hD;
    repeat (6) @(posedge clk_in);
    #1 check(window_ready_flag_out, 2'h2);
  endtask
  task automatic t_misc();
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, 32'h0);
    rd(`CIS_OFF_P0_A_CFG, 32'h77);
    rd(`CIS_OFF_VERSION, `CIS_VERSION_VALUE);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(`CIS_OFF_P0_A_CFG, 32'h0);
  endtask
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_inputs(4'h0, APOS, ANEG);
    t_inputs(4'h1, BPOS, BNEG);
    t_inputs(4'h4, APOS, ANEG);
    t_inputs(4'h5, BPOS, BNEG);
    t_window();
    t_ready();
    t_misc();
    give_verdict();
  end
endmodule // comparator_input_select_test
bind comparator_input_select comparator_input_select_checker u_comparator_input_select_checker (
  .clk_in(clk_in), .resetn_in(resetn_in), .wr_in(wr_in), .addr_in(addr_in),
  .comparator_ready_in(comparator_ready_in), .wdata_in(wdata_in),
  .window_ready_flag_out(window_ready_flag_out),
  .pair0_comparator_a_pos_out(pair0_comparator_a_pos_out),
  .pair0_comparator_a_neg_out(pair0_comparator_a_neg_out),
  .pair0_comparator_b_pos_out(pair0_comparator_b_pos_out),
  .pair0_comparator_b_neg_out(pair0_comparator_b_neg_out),
  .pair1_comparator_a_neg_out(pair1_comparator_a_neg_out));
